// >>> verilog/tbg_timer.sv
// Purpose: Timer B as a 16-bit baud rate generator with APB registers.
// Assumes: pclk is the oscillator; t1_overflow is a same-clock pulse.
// Notes:   Capture and reload on the trigger pin are kept outside baud mode.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module tbg_timer (
	// APB clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB request.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	// APB answer.
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Device pins.
	input  wire logic        external_count_pin,
	input  wire logic        trigger_input_pin,
	// Timer one overflow pulse.
	input  wire logic        t1_overflow,
	// Serial port rate pulses.
	output logic             tx_rate_tick,
	output logic             rx_rate_tick,
	output logic             tx_bit_tick,
	output logic             rx_bit_tick,
	// Interrupt.
	output logic             irq
);

	// Register state.
	logic [5:0]  ctrl_reg, ctrl_next;
	logic [1:0]  mode_reg, mode_next;
	logic [15:0] count_reg, count_next;
	logic [15:0] reload_reg, reload_next;
	logic [1:0]  stat_reg, stat_next;
	logic [1:0]  mask_reg, mask_next;
	logic        six_reg, six_next;
	logic [3:0]  presc_reg, presc_next;
	logic        irq_reg, irq_next;
	// Bus answer state.
	logic        pready_reg, pready_next;
	logic        pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;
	// Rate pulses: index 0 transmit, index 1 receive.
	logic [1:0]  rate_reg, rate_next;
	logic [1:0]  bit_reg;
	// Decoded controls and events.
	logic        run, ct_sel, baud, tx_sel, rx_sel;
	logic        pin_fall, trig_fall;
	logic        presc_tick, cnt_step, cnt_wrap, trig_hit;
	logic        wr_go, rd_hit;
	logic [3:0]  div;
	logic [31:0] rd_data;

	// True when the bus address names the given register.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// Both pins are asynchronous and pass their own synchroniser.
	tbg_fall_detect u_count_pin (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (external_count_pin),
		.fall    (pin_fall)
	);

	tbg_fall_detect u_trig_pin (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (trigger_input_pin),
		.fall    (trig_fall)
	);

	// Control decode; baud mode exists only while a select bit is set.
	assign run    = ctrl_reg[tbg_pkg::CT_RUN];
	assign ct_sel = ctrl_reg[tbg_pkg::CT_CT];
	assign tx_sel = ctrl_reg[tbg_pkg::CT_TXSEL];
	assign rx_sel = ctrl_reg[tbg_pkg::CT_RXSEL];
	assign baud   = tx_sel | rx_sel;

	// Prescale divide: state time in baud mode, machine cycle otherwise.
	always_comb begin
		if (baud) begin
			div = six_reg ? tbg_pkg::DIV_BAUD_6 : tbg_pkg::DIV_BAUD_12;
		end else begin
			div = six_reg ? tbg_pkg::DIV_MC_6 : tbg_pkg::DIV_MC_12;
		end
		presc_tick = run && (presc_reg >= div - 4'h1);
		if (!run || presc_tick) begin
			presc_next = 4'h0;
		end else begin
			presc_next = presc_reg + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_reg <= 4'h0;
		end else begin
			presc_reg <= presc_next;
		end
	end

	// Count events; the pin source ignores the prescaler entirely.
	assign cnt_step = run && (ct_sel ? pin_fall : presc_tick);
	assign cnt_wrap = cnt_step && (count_reg == tbg_pkg::COUNT_TOP);
	assign trig_hit = ctrl_reg[tbg_pkg::CT_TRGEN] && trig_fall;

	// Bus strobes: a write lands only in the completing access cycle.
	assign wr_go  = psel && penable && pready_reg && pwrite;
	assign rd_hit = hit(paddr, tbg_pkg::OFF_CTRL) || hit(paddr, tbg_pkg::OFF_MODE) ||
		hit(paddr, tbg_pkg::OFF_COUNT) || hit(paddr, tbg_pkg::OFF_RELOAD) ||
		hit(paddr, tbg_pkg::OFF_ISTAT) || hit(paddr, tbg_pkg::OFF_IMASK) ||
		hit(paddr, tbg_pkg::OFF_CLKMODE);

	// Counter and reload pair; a wrap loads the reload value at once.
	always_comb begin
		count_next  = count_reg;
		reload_next = reload_reg;
		if (cnt_wrap) begin
			count_next = reload_reg;
		end else if (cnt_step) begin
			count_next = count_reg + 16'h0001;
		end else if (trig_hit && !baud) begin
			// Outside baud mode the trigger edge captures or reloads.
			if (ctrl_reg[tbg_pkg::CT_CPRL]) begin
				reload_next = count_reg;
			end else begin
				count_next = reload_reg;
			end
		end
		// Software writes win; they must only happen with the timer stopped.
		if (wr_go && hit(paddr, tbg_pkg::OFF_COUNT)) begin
			count_next = pwdata[15:0];
		end
		if (wr_go && hit(paddr, tbg_pkg::OFF_RELOAD)) begin
			reload_next = pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg  <= tbg_pkg::RST_COUNT;
			reload_reg <= tbg_pkg::RST_RELOAD;
		end else begin
			count_reg  <= count_next;
			reload_reg <= reload_next;
		end
	end

	// Configuration registers written by software.
	always_comb begin
		ctrl_next = ctrl_reg;
		mode_next = mode_reg;
		mask_next = mask_reg;
		six_next  = six_reg;
		if (wr_go && hit(paddr, tbg_pkg::OFF_CTRL)) begin
			ctrl_next = pwdata[5:0];
		end
		if (wr_go && hit(paddr, tbg_pkg::OFF_MODE)) begin
			mode_next = pwdata[1:0];
		end
		if (wr_go && hit(paddr, tbg_pkg::OFF_IMASK)) begin
			mask_next = pwdata[1:0];
		end
		if (wr_go && hit(paddr, tbg_pkg::OFF_CLKMODE)) begin
			six_next = pwdata[tbg_pkg::CK_SIX];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= tbg_pkg::RST_CTRL;
			mode_reg <= tbg_pkg::RST_MODE;
			mask_reg <= tbg_pkg::RST_MASK;
			six_reg  <= tbg_pkg::RST_SIX;
		end else begin
			ctrl_reg <= ctrl_next;
			mode_reg <= mode_next;
			mask_reg <= mask_next;
			six_reg  <= six_next;
		end
	end

	// Sticky flags: set wins over clear, so no event is lost.
	always_comb begin
		logic [1:0] set_v;
		logic [1:0] clr_v;
		set_v = 2'h0;
		clr_v = 2'h0;
		set_v[tbg_pkg::ST_OVF] = cnt_wrap && !baud;
		set_v[tbg_pkg::ST_TRG] = trig_hit;
		if (wr_go && hit(paddr, tbg_pkg::OFF_ISTAT)) begin
			clr_v = pwdata[1:0];
		end
		if (wr_go && hit(paddr, tbg_pkg::OFF_CTRL)) begin
			clr_v[tbg_pkg::ST_OVF] = ~pwdata[tbg_pkg::CT_OVFF];
			clr_v[tbg_pkg::ST_TRG] = ~pwdata[tbg_pkg::CT_TRGF];
		end
		stat_next = (stat_reg & ~clr_v) | set_v;
		irq_next  = |(stat_next & mask_next);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_reg <= tbg_pkg::RST_STAT;
			irq_reg  <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			irq_reg  <= irq_next;
		end
	end

	// Read mux; unimplemented and reserved bits read as zero.
	always_comb begin
		rd_data = 32'h0000_0000;
		if (hit(paddr, tbg_pkg::OFF_CTRL)) begin
			rd_data[7:0] = {stat_reg[tbg_pkg::ST_OVF], stat_reg[tbg_pkg::ST_TRG], ctrl_reg};
		end
		if (hit(paddr, tbg_pkg::OFF_MODE)) begin
			rd_data[1:0] = mode_reg;
		end
		if (hit(paddr, tbg_pkg::OFF_COUNT)) begin
			rd_data[15:0] = count_reg;
		end
		if (hit(paddr, tbg_pkg::OFF_RELOAD)) begin
			rd_data[15:0] = reload_reg;
		end
		if (hit(paddr, tbg_pkg::OFF_ISTAT)) begin
			rd_data[1:0] = stat_reg;
		end
		if (hit(paddr, tbg_pkg::OFF_IMASK)) begin
			rd_data[1:0] = mask_reg;
		end
		if (hit(paddr, tbg_pkg::OFF_CLKMODE)) begin
			rd_data[0] = six_reg;
		end
	end

	// One wait state keeps every answer signal straight from a flip-flop.
	always_comb begin
		pready_next  = psel && penable && !pready_reg;
		pslverr_next = pready_next && !rd_hit;
		prdata_next  = prdata_reg;
		if (psel && !penable) begin
			prdata_next = pwrite ? 32'h0000_0000 : rd_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg  <= prdata_next;
		end
	end

	// Source select for each direction, registered to a clean pulse.
	always_comb begin
		rate_next[0] = tx_sel ? cnt_wrap : t1_overflow;
		rate_next[1] = rx_sel ? cnt_wrap : t1_overflow;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_reg <= 2'h0;
		end else begin
			rate_reg <= rate_next;
		end
	end

	// Divide each direction's rate by sixteen to give one pulse per bit.
	genvar d;
	generate
		for (d = 0; d < 2; d = d + 1) begin : g_bit
			logic [3:0] cnt_reg, cnt_next;
			logic       tick_next;
			always_comb begin
				cnt_next  = cnt_reg;
				tick_next = 1'b0;
				if (rate_reg[d]) begin
					cnt_next  = cnt_reg + 4'h1;
					tick_next = (cnt_reg == tbg_pkg::BIT_LAST);
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_reg    <= 4'h0;
					bit_reg[d] <= 1'b0;
				end else begin
					cnt_reg    <= cnt_next;
					bit_reg[d] <= tick_next;
				end
			end
		end
	endgenerate

	// Outputs, each straight from a flip-flop.
	assign pready       = pready_reg;
	assign pslverr      = pslverr_reg;
	assign prdata       = prdata_reg;
	assign tx_rate_tick = rate_reg[0];
	assign rx_rate_tick = rate_reg[1];
	assign tx_bit_tick  = bit_reg[0];
	assign rx_bit_tick  = bit_reg[1];
	assign irq          = irq_reg;

	// Checks on source selection, reload, rates and flags.
	a_tx_source: assert property (@(posedge pclk) disable iff (!presetn)
		(tx_sel && cnt_wrap) |=> tx_rate_tick) else $error("tx tick missing");
	a_rx_source: assert property (@(posedge pclk) disable iff (!presetn)
		(!rx_sel && t1_overflow) |=> rx_rate_tick) else $error("rx tick missing");
	a_wrap_reload: assert property (@(posedge pclk) disable iff (!presetn)
		(cnt_wrap && !wr_go) |=> (count_reg == $past(reload_reg))) else $error("no reload");
	a_bit_divide: assert property (@(posedge pclk) disable iff (!presetn)
		tx_bit_tick |-> $past(tx_rate_tick)) else $error("bit tick without rate");
	a_fast_count: assert property (@(posedge pclk) disable iff (!presetn)
		(run && !ct_sel && baud && six_reg) |-> cnt_step) else $error("6-clk baud stall");
	a_machine_cycle: assert property (@(posedge pclk) disable iff (!presetn)
		(cnt_step && !ct_sel && !baud && $stable(ctrl_reg)) |=> !cnt_step [*5])
		else $error("machine cycle too short");
	a_baud_only: assert property (@(posedge pclk) disable iff (!presetn)
		(!baud && cnt_wrap && !t1_overflow) |=> !tx_rate_tick && !rx_rate_tick)
		else $error("timer B drove serial rate");
	a_no_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(cnt_wrap && baud && !stat_reg[tbg_pkg::ST_OVF]) |=> !stat_reg[tbg_pkg::ST_OVF])
		else $error("overflow flag in baud mode");
	a_trig_no_reload: assert property (@(posedge pclk) disable iff (!presetn)
		(trig_hit && baud && !cnt_step && !wr_go)
		|=> ($stable(count_reg) && stat_reg[tbg_pkg::ST_TRG])) else $error("trigger reload");
	a_pin_only: assert property (@(posedge pclk) disable iff (!presetn)
		(ct_sel && !pin_fall) |-> !cnt_step) else $error("count without pin edge");
	a_mode_bits: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && !pwrite && hit(paddr, tbg_pkg::OFF_MODE))
		|-> (prdata[31:2] == 30'h0)) else $error("mode upper bits set");

endmodule : tbg_timer

// >>> verilog/tbg_pkg.sv
// Purpose: Shared constants for the timer-B baud rate generator.
// Assumes: APB byte addressing of word-aligned registers, 32-bit data, pclk is the oscillator.
// Notes:   Offsets are byte addresses; fields are bit positions.
package tbg_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_MODE    = 8'h04;
	localparam logic [7:0] OFF_COUNT   = 8'h08;
	localparam logic [7:0] OFF_RELOAD  = 8'h0C;
	localparam logic [7:0] OFF_ISTAT   = 8'h10;
	localparam logic [7:0] OFF_IMASK   = 8'h14;
	localparam logic [7:0] OFF_CLKMODE = 8'h18;

	// Fields of timer_b_control.
	localparam int CT_CPRL  = 0;
	localparam int CT_CT    = 1;
	localparam int CT_RUN   = 2;
	localparam int CT_TRGEN = 3;
	localparam int CT_TXSEL = 4;
	localparam int CT_RXSEL = 5;
	localparam int CT_TRGF  = 6;
	localparam int CT_OVFF  = 7;

	// Fields of timer_b_mode_register.
	localparam int MD_UPDN = 0;
	localparam int MD_OE   = 1;

	// Fields of the interrupt status and mask registers.
	localparam int ST_OVF = 0;
	localparam int ST_TRG = 1;

	// Field of the clock mode register: one selects 6-clock mode.
	localparam int CK_SIX = 0;

	// Reset values.
	localparam logic [5:0]  RST_CTRL   = 6'h00;
	localparam logic [1:0]  RST_MODE   = 2'h0;
	localparam logic [15:0] RST_COUNT  = 16'h0000;
	localparam logic [15:0] RST_RELOAD = 16'h0000;
	localparam logic [1:0]  RST_STAT   = 2'h0;
	localparam logic [1:0]  RST_MASK   = 2'h0;
	localparam logic        RST_SIX    = 1'b0;

	// Oscillator cycles per count step.
	localparam logic [3:0] DIV_BAUD_6  = 4'h1;
	localparam logic [3:0] DIV_BAUD_12 = 4'h2;
	localparam logic [3:0] DIV_MC_6    = 4'h6;
	localparam logic [3:0] DIV_MC_12   = 4'hC;

	// Last rate tick index of a serial bit, and the top of the count.
	localparam logic [3:0]  BIT_LAST  = 4'hF;
	localparam logic [15:0] COUNT_TOP = 16'hFFFF;

endpackage : tbg_pkg

// >>> verilog/tbg_fall_detect.sv
// Purpose: Synchronise a pin and flag its falling edges.
// Assumes: The pin is asynchronous to pclk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module tbg_fall_detect (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Pin and edge pulse.
	input  wire logic pin,
	output logic      fall
);

	logic s1_reg, s2_reg, s3_reg, fall_reg;
	logic s1_next, s2_next, s3_next, fall_next;

	// Two synchroniser stages, then one stage for the edge compare.
	always_comb begin
		s1_next   = pin;
		s2_next   = s1_reg;
		s3_next   = s2_reg;
		fall_next = s3_reg & ~s2_reg;
	end

	// Idle high so that a pin held high at reset gives no false edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg   <= 1'b1;
			s2_reg   <= 1'b1;
			s3_reg   <= 1'b1;
			fall_reg <= 1'b0;
		end else begin
			s1_reg   <= s1_next;
			s2_reg   <= s2_next;
			s3_reg   <= s3_next;
			fall_reg <= fall_next;
		end
	end

	assign fall = fall_reg;

endmodule : tbg_fall_detect

// >>> test/tbg_serial_model.sv
// Purpose: Serial side model: timer one overflow source and bit tick tally.
// Assumes: Same clock as the timer block; every pulse lasts one cycle.
// Notes:   Timer one runs free from reset so a fallback rate always exists.
`timescale 1ns/1ps
module tbg_serial_model #(
	parameter int T1_PERIOD = 10
) (
	// Clock and reset.
	input  wire logic  pclk,
	input  wire logic  presetn,
	// Bit pulses from the timer block.
	input  wire logic  tx_bit_tick,
	input  wire logic  rx_bit_tick,
	// Timer one overflow and bit count.
	output logic       t1_overflow,
	output logic [7:0] bits_seen
);
	int div_reg;

	// Fixed divider; the pulse is registered so it never races the timer block.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= 0;
			t1_overflow <= 1'b0;
			bits_seen <= 8'h00;
		end else begin
			div_reg <= (div_reg == T1_PERIOD - 1) ? 0 : div_reg + 1;
			t1_overflow <= (div_reg == T1_PERIOD - 1);
			bits_seen <= bits_seen + 8'(tx_bit_tick) + 8'(rx_bit_tick);
		end
	end
endmodule : tbg_serial_model

// >>> test/tbg_timer_tb.sv
// Purpose: Self-checking bench for the timer B baud rate generator.
// Assumes: APB answers after a bounded wait; timer one period is 10 cycles.
// Notes:   Rate rows first, then reset, flags, pins and machine-cycle count.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %s exp=%0h got=%0h", nm, e, g); end end
module tbg_timer_tb;
	typedef struct {logic [7:0] code; logic six; int txg; int rxg; logic ovf;} tbg_row_s;
	localparam int          T1P    = 10;
	localparam logic [31:0] RELOAD = 32'h0000FFF0;
	localparam int          STEPS  = 16;
	localparam int          D6     = int'(tbg_pkg::DIV_BAUD_6);
	localparam int          D12    = int'(tbg_pkg::DIV_BAUD_12);
	localparam int          MC_WAIT = 120;
	localparam int          D_MC12 = int'(tbg_pkg::DIV_MC_12);
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, bits_seen, b0;
	logic [31:0] pwdata, prdata, rd;
	logic        ext_pin, trg_pin, t1_overflow, irq, tx_rt, rx_rt, tx_bt, rx_bt;
	wire  [3:0]  ticks = {rx_bt, tx_bt, rx_rt, tx_rt};
	int          bad_count, total_checks, n;
	tbg_row_s    rows[5];
	logic [7:0]  offs[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};

	tbg_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .external_count_pin(ext_pin),
		.trigger_input_pin(trg_pin), .t1_overflow(t1_overflow), .tx_rate_tick(tx_rt),
		.rx_rate_tick(rx_rt), .tx_bit_tick(tx_bt), .rx_bit_tick(rx_bt), .irq(irq));
	tbg_serial_model #(.T1_PERIOD(T1P)) partner (.pclk(pclk), .presetn(presetn),
		.tx_bit_tick(tx_bt), .rx_bit_tick(rx_bt), .t1_overflow(t1_overflow),
		.bits_seen(bits_seen));

	// Free-running 10 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic finish_test;
		$display("checks=%0d errors=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	// One APB transfer; the request holds until pready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK($sformatf("reg %0h", a), e, rd)
	endtask : rdchk

	// Cycles between two pulses of one tick output, bounded.
	task automatic gap(input int idx, output int g);
		int i;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (ticks[idx] !== 1'b1 && i < 3000);
		g = 0;
		do begin
			@(posedge pclk);
			g++;
		end while (ticks[idx] !== 1'b1 && g < 3000);
		if (g >= 3000) begin
			bad_count++;
			finish_test();
		end
	endtask : gap

	// One falling edge on the trigger pin (0) or the count pin (1).
	task automatic fall(input int which);
		@(posedge pclk);
		if (which == 1) ext_pin <= 1'b0; else trg_pin <= 1'b0;
		repeat (4) @(posedge pclk);
		if (which == 1) ext_pin <= 1'b1; else trg_pin <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask : fall

	// Main sequence.
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		ext_pin = 1'b1;
		trg_pin = 1'b1;
		presetn = 1'b0;
		bad_count = 0;
		total_checks = 0;
		rows[0] = '{8'h34, 1'b1, STEPS * D6, STEPS * D6, 1'b0};
		rows[1] = '{8'h34, 1'b0, STEPS * D12, STEPS * D12, 1'b0};
		rows[2] = '{8'h14, 1'b1, STEPS * D6, T1P, 1'b0};
		rows[3] = '{8'h24, 1'b1, T1P, STEPS * D6, 1'b0};
		rows[4] = '{8'h04, 1'b1, T1P, T1P, 1'b1};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		wr(tbg_pkg::OFF_IMASK, 32'h3);
		// Stop, clear and load before each start, as software must.
		foreach (rows[k]) begin
			wr(tbg_pkg::OFF_CTRL, 32'h0);
			wr(tbg_pkg::OFF_ISTAT, 32'h3);
			wr(tbg_pkg::OFF_CLKMODE, {31'h0, rows[k].six});
			wr(tbg_pkg::OFF_COUNT, RELOAD);
			wr(tbg_pkg::OFF_RELOAD, RELOAD);
			wr(tbg_pkg::OFF_CTRL, {24'h0, rows[k].code});
			gap(0, n);
			`CHK("tx gap", rows[k].txg, n)
			gap(1, n);
			`CHK("rx gap", rows[k].rxg, n)
			repeat (200) @(posedge pclk);
			rdchk(tbg_pkg::OFF_ISTAT, {31'h0, rows[k].ovf});
			`CHK("irq", rows[k].ovf, irq)
		end
		wr(tbg_pkg::OFF_CTRL, 32'h0);
		wr(tbg_pkg::OFF_CTRL, 32'h34);
		b0 = bits_seen;
		gap(2, n);
		`CHK("tx bit gap", 16 * STEPS * D6, n)
		gap(3, n);
		`CHK("rx bit gap", 16 * STEPS * D6, n)
		// The serial side must have tallied the bit pulses it was sent.
		`CHK("bits tallied", 1'b1, ((bits_seen - b0) >= 8'd2))
		wr(tbg_pkg::OFF_MODE, 32'hFF);
		rdchk(tbg_pkg::OFF_MODE, 32'h3);
		apb(1'b0, 8'h1C, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		// Reset in mid-run must silence every tick output and restore the registers.
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK("ticks in reset", 4'h0, ticks)
		`CHK("bits in reset", 8'h00, bits_seen)
		presetn <= 1'b1;
		foreach (offs[k]) rdchk(offs[k], 32'h0);
		// Trigger edge in baud mode with pin counting: flag only, no reload.
		wr(tbg_pkg::OFF_IMASK, 32'h3);
		wr(tbg_pkg::OFF_COUNT, 32'h5);
		wr(tbg_pkg::OFF_RELOAD, RELOAD);
		wr(tbg_pkg::OFF_CTRL, 32'h3E);
		fall(0);
		rdchk(tbg_pkg::OFF_CTRL, 32'h7E);
		`CHK("irq trig", 1'b1, irq)
		wr(tbg_pkg::OFF_IMASK, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK("irq masked", 1'b0, irq)
		repeat (3) fall(1);
		// Bit six written as one keeps the trigger flag while the timer stops.
		wr(tbg_pkg::OFF_CTRL, 32'h72);
		rdchk(tbg_pkg::OFF_COUNT, 32'h8);
		rdchk(tbg_pkg::OFF_ISTAT, 32'h2);
		wr(tbg_pkg::OFF_ISTAT, 32'h2);
		rdchk(tbg_pkg::OFF_ISTAT, 32'h0);
		// Outside baud mode in 12-clock mode: one step per 12 cycles.
		wr(tbg_pkg::OFF_CTRL, 32'h0);
		wr(tbg_pkg::OFF_COUNT, 32'h0);
		wr(tbg_pkg::OFF_CLKMODE, 32'h0);
		wr(tbg_pkg::OFF_CTRL, 32'h04);
		repeat (MC_WAIT) @(posedge pclk);
		wr(tbg_pkg::OFF_CTRL, 32'h0);
		apb(1'b0, tbg_pkg::OFF_COUNT, 32'h0);
		`CHK("machine cycle count", 32'(MC_WAIT / D_MC12), rd)
		// Outside baud mode the trigger edge captures, then reloads, the count.
		wr(tbg_pkg::OFF_CTRL, 32'h09);
		fall(0);
		rdchk(tbg_pkg::OFF_RELOAD, 32'(MC_WAIT / D_MC12));
		wr(tbg_pkg::OFF_CTRL, 32'h08);
		wr(tbg_pkg::OFF_COUNT, 32'h1234);
		fall(0);
		rdchk(tbg_pkg::OFF_COUNT, 32'(MC_WAIT / D_MC12));
		rdchk(tbg_pkg::OFF_ISTAT, 32'h2);
		finish_test();
	end
endmodule : tbg_timer_tb
